// ### rtl/two_wire_master_irq_enable.sv
//----------------------------------------------------------------------------
// Purpose: Interrupt enable set/clear/plain registers, sticky event status
//          and the combined interrupt line of the two-wire bus master
// Assumes: Event pulses come from logic on clk; one write and one read
//          outstanding at most, as AXI4-Lite masters normally behave
// Notes:   Every output is a flip-flop; write answer two edges after the
//          later of address and data, read answer one edge after address
//----------------------------------------------------------------------------
//
// Local design decision: the AXI4-Lite slave port.
module two_wire_master_irq_enable
    import twm_irq_pkg::*;
(
    input  wire logic        clk,                  // Peripheral clock
    input  wire logic        rstn,                 // Async reset, active low
    // Events from the protocol engine, one-cycle pulses
    input  wire logic        halt_done_event,      // Transfer halted
    input  wire logic        bus_error_event,      // Bus error seen
    input  wire logic        pause_event,          // Transfer paused
    input  wire logic        receive_begun_event,  // Receive started
    input  wire logic        transmit_begun_event, // Transmit started
    input  wire logic        final_byte_received_event, // Last byte in
    input  wire logic        final_byte_sent_event,     // Last byte out
    // AXI4-Lite write address
    input  wire logic [11:0] s_axi_awaddr,         // Write byte address
    input  wire logic [2:0]  s_axi_awprot,         // Protection, unused
    input  wire logic        s_axi_awvalid,        // Address valid
    output logic             s_axi_awready,        // Address taken
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,          // Write data
    input  wire logic [3:0]  s_axi_wstrb,          // Byte enables
    input  wire logic        s_axi_wvalid,         // Data valid
    output logic             s_axi_wready,         // Data taken
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,          // Write status
    output logic             s_axi_bvalid,         // Response valid
    input  wire logic        s_axi_bready,         // Master accepts
    // AXI4-Lite read address
    input  wire logic [11:0] s_axi_araddr,         // Read byte address
    input  wire logic [2:0]  s_axi_arprot,         // Protection, unused
    input  wire logic        s_axi_arvalid,        // Address valid
    output logic             s_axi_arready,        // Address taken
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,          // Read data
    output logic [1:0]       s_axi_rresp,          // Read status
    output logic             s_axi_rvalid,         // Data valid
    input  wire logic        s_axi_rready,         // Master accepts
    // Interrupt
    output logic             irq                   // Level, active high
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Expands byte enables into a bit mask limited to implemented bits
    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m & EVENT_BITS_MASK;
    endfunction

    // Word-aligned decode: is the address one of the mapped registers
    function automatic logic is_mapped(input logic [11:0] addr);
        logic hit;
        hit = (addr == OFS_EVENT_STATUS)     ||
              (addr == OFS_IRQ_ENABLE_PLAIN) ||
              (addr == OFS_IRQ_ENABLE_SET)   ||
              (addr == OFS_IRQ_ENABLE_CLEAR);
        return hit;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [31:0] irq_enable_q;    // Single store behind all enable views
    logic [31:0] event_status_q;  // Sticky event flags
    logic [31:0] event_pulse;     // Events placed on their bit positions

    wr_state_t   wr_state_q;
    logic        aw_have_q;
    logic [11:0] aw_addr_q;
    logic        w_have_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;

    logic        s_axi_awready_q;
    logic        s_axi_wready_q;
    logic        s_axi_bvalid_q;
    logic [1:0]  s_axi_bresp_q;
    logic        s_axi_arready_q;
    logic        s_axi_rvalid_q;
    logic [31:0] s_axi_rdata_q;
    logic [1:0]  s_axi_rresp_q;
    logic        irq_q;

    // ------------------------------------------------------------------
    // Combinational handshake terms
    // ------------------------------------------------------------------
    logic        aw_take;
    logic        w_take;
    logic        b_done;
    logic        commit;
    logic        ar_take;
    logic        r_done;
    logic        aw_have_d;
    logic        w_have_d;
    logic        wr_idle_d;
    logic [31:0] wr_bits;        // Written ones, strobed and masked
    logic        wr_plain;
    logic        wr_set;
    logic        wr_clear;
    logic        wr_status;

    // Handshakes of each channel
    assign aw_take = s_axi_awvalid & s_axi_awready_q;
    assign w_take  = s_axi_wvalid  & s_axi_wready_q;
    assign b_done  = s_axi_bvalid_q & s_axi_bready;
    assign ar_take = s_axi_arvalid & s_axi_arready_q;
    assign r_done  = s_axi_rvalid_q & s_axi_rready;

    // A write lands once both halves are held; order of arrival is free
    assign commit  = (wr_state_q == WR_COLLECT) & aw_have_q & w_have_q;

    // Next holding state, so the ready flops can look one edge ahead
    assign aw_have_d = (aw_have_q | aw_take) & ~commit;
    assign w_have_d  = (w_have_q  | w_take)  & ~commit;
    assign wr_idle_d = commit ? 1'b0 :
                       ((wr_state_q == WR_COLLECT) | b_done);

    // Decode of a committing write
    assign wr_bits   = w_data_q & lane_mask(w_strb_q);
    assign wr_plain  = commit & (aw_addr_q == OFS_IRQ_ENABLE_PLAIN);
    assign wr_set    = commit & (aw_addr_q == OFS_IRQ_ENABLE_SET);
    assign wr_clear  = commit & (aw_addr_q == OFS_IRQ_ENABLE_CLEAR);
    assign wr_status = commit & (aw_addr_q == OFS_EVENT_STATUS);

    // Place each event pulse on its bit
    always_comb begin
        event_pulse = 32'h0000_0000;
        event_pulse[BIT_HALT_DONE]      = halt_done_event;
        event_pulse[BIT_BUS_ERROR]      = bus_error_event;
        event_pulse[BIT_PAUSE]          = pause_event;
        event_pulse[BIT_RECEIVE_BEGUN]  = receive_begun_event;
        event_pulse[BIT_TRANSMIT_BEGUN] = transmit_begun_event;
        event_pulse[BIT_FINAL_RX]       = final_byte_received_event;
        event_pulse[BIT_FINAL_TX]       = final_byte_sent_event;
    end

    // ------------------------------------------------------------------
    // Write address and data capture
    // ------------------------------------------------------------------

    // Address is held until the write commits
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 12'h000;
        end else begin
            aw_have_q <= aw_have_d;
            if (aw_take) begin
                aw_addr_q <= {s_axi_awaddr[11:2], 2'b00};
            end
        end
    end

    // Data and strobes are held until the write commits
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            w_have_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else begin
            w_have_q <= w_have_d;
            if (w_take) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
        end
    end

    // Ready drops as soon as a half is held, so a second write waits
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_awready_q <= 1'b0;
            s_axi_wready_q  <= 1'b0;
        end else begin
            s_axi_awready_q <= wr_idle_d & ~aw_have_d;
            s_axi_wready_q  <= wr_idle_d & ~w_have_d;
        end
    end

    // ------------------------------------------------------------------
    // Write response
    // ------------------------------------------------------------------

    // Response stands until the master takes it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_state_q     <= WR_COLLECT;
            s_axi_bvalid_q <= 1'b0;
            s_axi_bresp_q  <= RESP_OKAY;
        end else begin
            case (wr_state_q)
                WR_COLLECT: begin
                    if (commit) begin
                        wr_state_q     <= WR_RESPOND;
                        s_axi_bvalid_q <= 1'b1;
                        s_axi_bresp_q  <= is_mapped(aw_addr_q) ?
                                          RESP_OKAY : RESP_SLVERR;
                    end
                end
                WR_RESPOND: begin
                    if (b_done) begin
                        wr_state_q     <= WR_COLLECT;
                        s_axi_bvalid_q <= 1'b0;
                        s_axi_bresp_q  <= RESP_OKAY;
                    end
                end
                default: begin
                    wr_state_q     <= WR_COLLECT;
                    s_axi_bvalid_q <= 1'b0;
                    s_axi_bresp_q  <= RESP_OKAY;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Interrupt enable store
    // ------------------------------------------------------------------

    // One store serves all three views, so they never disagree. Zero bits
    // of a set or clear write fall out of the OR and the AND-NOT.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_enable_q <= RST_IRQ_ENABLE;
        end else if (wr_plain) begin
            irq_enable_q <= (irq_enable_q & ~lane_mask(w_strb_q))
                            | wr_bits;
        end else if (wr_set) begin
            irq_enable_q <= irq_enable_q | wr_bits;
        end else if (wr_clear) begin
            irq_enable_q <= irq_enable_q & ~wr_bits;
        end
    end

    // ------------------------------------------------------------------
    // Sticky event status
    // ------------------------------------------------------------------

    // Write one to clear; a pulse in the clearing cycle survives, since
    // losing it would hide an event the engine already reported
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            event_status_q <= RST_EVENT_STATUS;
        end else if (wr_status) begin
            event_status_q <= (event_status_q & ~wr_bits) | event_pulse;
        end else begin
            event_status_q <= event_status_q | event_pulse;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------------

    // Level, registered; follows flags and enables one edge later
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(event_status_q & irq_enable_q);
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------

    // Address ready only while no read data is waiting
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready_q <= 1'b0;
        end else begin
            s_axi_arready_q <= ~(ar_take | (s_axi_rvalid_q & ~r_done));
        end
    end

    // Read data: every enable view returns the live enable state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid_q <= 1'b0;
            s_axi_rdata_q  <= 32'h0000_0000;
            s_axi_rresp_q  <= RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid_q <= 1'b1;
            s_axi_rresp_q  <= RESP_OKAY;
            case ({s_axi_araddr[11:2], 2'b00})
                OFS_IRQ_ENABLE_PLAIN,
                OFS_IRQ_ENABLE_SET,
                OFS_IRQ_ENABLE_CLEAR: begin
                    s_axi_rdata_q <= irq_enable_q & EVENT_BITS_MASK;
                end
                OFS_EVENT_STATUS: begin
                    s_axi_rdata_q <= event_status_q & EVENT_BITS_MASK;
                end
                default: begin
                    s_axi_rdata_q <= 32'h0000_0000;
                    s_axi_rresp_q <= RESP_SLVERR;
                end
            endcase
        end else if (r_done) begin
            s_axi_rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Output connections, all straight from flip-flops
    // ------------------------------------------------------------------
    assign s_axi_awready = s_axi_awready_q;
    assign s_axi_wready  = s_axi_wready_q;
    assign s_axi_bvalid  = s_axi_bvalid_q;
    assign s_axi_bresp   = s_axi_bresp_q;
    assign s_axi_arready = s_axi_arready_q;
    assign s_axi_rvalid  = s_axi_rvalid_q;
    assign s_axi_rdata   = s_axi_rdata_q;
    assign s_axi_rresp   = s_axi_rresp_q;
    assign irq           = irq_q;

endmodule

// ### rtl/twm_irq_pkg.sv
//----------------------------------------------------------------------------
// Purpose: Constants for the two-wire master interrupt-enable block
// Assumes: 32-bit AXI4-Lite register bus, one word per register
// Notes:   Enable bits share one layout across all enable views
//----------------------------------------------------------------------------
// Contract
// - Writing 1 to set-register halt-done bit enables it; read shows enable.
// - Writing 1 to set-register error bit enables it; read shows enable.
// - Writing 1 to set-register pause bit enables it; read shows enable.
// - Writing 1 to set-register receive-begun bit enables it; read shows it.
// - Writing 1 to set-register transmit-begun bit enables it; read shows it.
// - Writing 1 to set-register final-byte-received bit enables it.
// - Writing 1 to set-register final-byte-sent bit enables it.
// - Writing 1 to clear-register halt-done bit disables it; read shows it.
// - Writing 1 to clear-register error bit disables it; read shows it.
// - Writing 1 to clear-register pause bit disables it; read shows it.
// - Writing 1 to clear-register receive-begun bit disables it.
// - Writing 1 to clear-register transmit-begun bit disables it.
// - Writing 1 to clear-register final-byte-received bit disables it.
// - Writing 1 to clear-register final-byte-sent bit disables it.
// - Plain enable register holds the same bits that set and clear modify.
package twm_irq_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_EVENT_STATUS     = 12'h100;
    localparam logic [11:0] OFS_IRQ_ENABLE_PLAIN = 12'h300;
    localparam logic [11:0] OFS_IRQ_ENABLE_SET   = 12'h304;
    localparam logic [11:0] OFS_IRQ_ENABLE_CLEAR = 12'h308;

    // ------------------------------------------------------------------
    // Event bit positions, common to status and every enable view
    // ------------------------------------------------------------------
    localparam int BIT_HALT_DONE      = 0;
    localparam int BIT_BUS_ERROR      = 3;
    localparam int BIT_PAUSE          = 5;
    localparam int BIT_RECEIVE_BEGUN  = 6;
    localparam int BIT_TRANSMIT_BEGUN = 7;
    localparam int BIT_FINAL_RX       = 8;
    localparam int BIT_FINAL_TX       = 9;

    // Implemented bits; all others read as zero
    localparam logic [31:0] EVENT_BITS_MASK = 32'h0000_03e9;

    // Reset values
    localparam logic [31:0] RST_IRQ_ENABLE   = 32'h0000_0000;
    localparam logic [31:0] RST_EVENT_STATUS = 32'h0000_0000;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Write channel sequencing
    typedef enum logic [0:0] {
        WR_COLLECT,
        WR_RESPOND
    } wr_state_t;

endpackage

// ### verification/twm_irq_chk.sv
//------------------------------------------------------------------
// Purpose: Bus and interrupt timing checks for the enable block
// Assumes: The bench offers write address and data in one cycle
// Notes:   Sees only the top ports; attached by the bind below
//------------------------------------------------------------------
module twm_irq_chk (
    input wire logic        clk,                       // Clock
    input wire logic        rstn,                      // Reset, low
    input wire logic        halt_done_event,           // Event
    input wire logic        bus_error_event,           // Event
    input wire logic        pause_event,               // Event
    input wire logic        receive_begun_event,       // Event
    input wire logic        transmit_begun_event,      // Event
    input wire logic        final_byte_received_event, // Event
    input wire logic        final_byte_sent_event,     // Event
    input wire logic        s_axi_awvalid,             // AW valid
    input wire logic        s_axi_awready,             // AW ready
    input wire logic        s_axi_wvalid,              // W valid
    input wire logic        s_axi_wready,              // W ready
    input wire logic [1:0]  s_axi_bresp,               // B status
    input wire logic        s_axi_bvalid,              // B valid
    input wire logic        s_axi_bready,              // B ready
    input wire logic [11:0] s_axi_araddr,              // AR address
    input wire logic        s_axi_arvalid,             // AR valid
    input wire logic        s_axi_arready,             // AR ready
    input wire logic [31:0] s_axi_rdata,               // R data
    input wire logic [1:0]  s_axi_rresp,               // R status
    input wire logic        s_axi_rvalid,              // R valid
    input wire logic        s_axi_rready,              // R ready
    input wire logic        irq                        // Interrupt
);
    import twm_irq_pkg::*;
    // Any event; a read of no mapped register
    logic ev_any;
    logic ar_bad;
    assign ev_any = |{halt_done_event, bus_error_event, pause_event,
        receive_begun_event, transmit_begun_event,
        final_byte_received_event, final_byte_sent_event};
    assign ar_bad = !(s_axi_araddr[11:2] inside {OFS_EVENT_STATUS[11:2],
        OFS_IRQ_ENABLE_PLAIN[11:2], OFS_IRQ_ENABLE_SET[11:2],
        OFS_IRQ_ENABLE_CLEAR[11:2]});
    // One clock domain, so one default clock and reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Handshakes that open a write or a read
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // Exact delays: a hung answer would stall software
    property p_wr_answer;
        s_wr_take |=> !s_axi_awready ##1 s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("late bvalid");
    property p_rd_answer;
        s_rd_take |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("late rvalid");
    property p_rd_bad;
        s_rd_take ##0 ar_bad |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_rd_bad: assert property (p_rd_bad) else $error("bad read answer");
    property p_rd_good;
        s_rd_take ##0 !ar_bad |=> s_axi_rresp == RESP_OKAY;
    endproperty
    a_rd_good: assert property (p_rd_good) else $error("good read failed");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bresp dropped");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("rdata dropped");
    property p_irq_rise;
        $rose(irq) |-> $past(ev_any, 2) || $past(s_axi_bvalid);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq from nothing");
    property p_irq_fall;
        $fell(irq) |-> $past(s_axi_bvalid);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
endmodule
bind two_wire_master_irq_enable twm_irq_chk i_chk (.*);

// ### verification/two_wire_master_irq_enable_tb.sv
//------------------------------------------------------------------
// Purpose: Self-checking bench for the interrupt enable block
// Assumes: Inputs change by non-blocking writes at the rising edge
// Notes:   Bus waits are open-ended; the watchdog ends a hang
//------------------------------------------------------------------
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
`define RD_CHK(a, e) begin axi_rd(a); `CHK(rd_r, RESP_OKAY) `CHK(rd_d, e) end
module two_wire_master_irq_enable_tb
    import twm_irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int POS [7] = '{BIT_HALT_DONE, BIT_BUS_ERROR, BIT_PAUSE,
        BIT_RECEIVE_BEGUN, BIT_TRANSMIT_BEGUN, BIT_FINAL_RX, BIT_FINAL_TX};
    logic        clk = 1'b0;
    logic        rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, stall;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [6:0]  ev;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r, wr_r;
    int          errors = 0;
    int          num_checks = 0;

    // 10 MHz clock
    always #50 clk = ~clk;

    two_wire_master_irq_enable i_dut (
        .clk(clk), .rstn(rstn), .halt_done_event(ev[0]),
        .bus_error_event(ev[1]), .pause_event(ev[2]),
        .receive_begun_event(ev[3]), .transmit_begun_event(ev[4]),
        .final_byte_received_event(ev[5]), .final_byte_sent_event(ev[6]),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .irq(irq));

    function automatic logic [31:0] bm(input int i);
        return 32'h1 << POS[i];
    endfunction

    // Write: AW and W together, each dropped once taken; stall delays bready
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                          input logic [3:0] s);
        bit aw_ok, w_ok;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= !stall;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready)
                aw_ok = 1'b1;
            if (s_axi_wvalid && s_axi_wready)
                w_ok = 1'b1;
            s_axi_awvalid <= s_axi_awvalid && !aw_ok;
            s_axi_wvalid <= s_axi_wvalid && !w_ok;
        end
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        if (stall) begin
            repeat (2) @(posedge clk);
            s_axi_bready <= 1'b1;
            @(posedge clk);
        end
        wr_r = s_axi_bresp;
    endtask

    // Read: data and status taken at the rready handshake edge
    task automatic axi_rd(input logic [11:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= !stall;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        if (stall) begin
            repeat (2) @(posedge clk);
            s_axi_rready <= 1'b1;
            @(posedge clk);
        end
        rd_d = s_axi_rdata;
        rd_r = s_axi_rresp;
    endtask

    // One-cycle event pulse, then settling time
    task automatic pulse(input int i);
        ev <= 7'(1 << i);
        @(posedge clk);
        ev <= '0;
        repeat (2) @(posedge clk);
    endtask

    task automatic close_out();
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Set bits one by one; zeros elsewhere must not disturb others
    task automatic t_set_clr();
        logic [31:0] exp;
        exp = RST_IRQ_ENABLE;
        `RD_CHK(OFS_IRQ_ENABLE_SET, RST_IRQ_ENABLE)
        `RD_CHK(OFS_EVENT_STATUS, RST_EVENT_STATUS)
        for (int i = 0; i < 7; i++) begin
            axi_wr(OFS_IRQ_ENABLE_SET, bm(i), 4'hf);
            exp = exp | bm(i);
            `RD_CHK(OFS_IRQ_ENABLE_SET, exp)
        end
        for (int i = 0; i < 7; i++) begin
            axi_wr(OFS_IRQ_ENABLE_CLEAR, bm(i), 4'hf);
            exp = exp & ~bm(i);
            `RD_CHK(OFS_IRQ_ENABLE_CLEAR, exp)
            `RD_CHK(OFS_IRQ_ENABLE_PLAIN, exp)
        end
    endtask

    // Plain register, partial strobe; zero writes to set/clear
    task automatic t_plain();
        axi_wr(OFS_IRQ_ENABLE_PLAIN, 32'hffff_ffff, 4'h1);
        `RD_CHK(OFS_IRQ_ENABLE_SET, 32'h0000_00e9)
        axi_wr(OFS_IRQ_ENABLE_CLEAR, 32'h0, 4'hf);
        axi_wr(OFS_IRQ_ENABLE_SET, 32'h0, 4'hf);
        `RD_CHK(OFS_IRQ_ENABLE_CLEAR, 32'h0000_00e9)
        axi_wr(OFS_IRQ_ENABLE_PLAIN, 32'hffff_ffff, 4'hf);
        `RD_CHK(OFS_IRQ_ENABLE_PLAIN, EVENT_BITS_MASK)
        axi_wr(OFS_IRQ_ENABLE_PLAIN, 32'h0, 4'hf);
    endtask

    // Each event: masked, unmasked late, masked again, then event-led
    task automatic t_irq();
        for (int i = 0; i < 7; i++) begin
            pulse(i);
            `CHK(irq, 1'b0)
            `RD_CHK(OFS_EVENT_STATUS, bm(i))
            axi_wr(OFS_IRQ_ENABLE_SET, bm(i), 4'hf);
            repeat (2) @(posedge clk);
            `CHK(irq, 1'b1)
            axi_wr(OFS_IRQ_ENABLE_CLEAR, bm(i), 4'hf);
            repeat (2) @(posedge clk);
            `CHK(irq, 1'b0)
            axi_wr(OFS_IRQ_ENABLE_SET, bm(i), 4'hf);
            axi_wr(OFS_EVENT_STATUS, bm(i), 4'hf);
            pulse(i);
            `CHK(irq, 1'b1)
            axi_wr(OFS_EVENT_STATUS, bm(i), 4'hf);
            repeat (2) @(posedge clk);
            `CHK(irq, 1'b0)
            axi_wr(OFS_IRQ_ENABLE_CLEAR, bm(i), 4'hf);
        end
    endtask

    // Unmapped places with a slow master, then a reset in mid-run
    task automatic t_odd();
        stall = 1'b1;
        axi_wr(12'h200, 32'hffff_ffff, 4'hf);
        `CHK(wr_r, RESP_SLVERR)
        axi_rd(12'h30c);
        `CHK(rd_r, RESP_SLVERR)
        `RD_CHK(OFS_IRQ_ENABLE_PLAIN, 32'h0)
        stall = 1'b0;
        axi_wr(OFS_IRQ_ENABLE_SET, EVENT_BITS_MASK, 4'hf);
        pulse(2);
        `CHK(irq, 1'b1)
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        `RD_CHK(OFS_IRQ_ENABLE_PLAIN, RST_IRQ_ENABLE)
    endtask

    // Main sequence
    initial begin
        {rstn, ev, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
         s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata,
         s_axi_wstrb, stall} <= '0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        t_set_clr();
        t_plain();
        t_irq();
        t_odd();
        close_out();
    end

    // Watchdog: the run needs under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        close_out();
    end
endmodule
